/* hw/dcpwm_regs.vh */
// Register indices, field positions and reset values of the dual counter PWM unit.
// Assumes the includer maps index N to APB byte address 4*N.
`ifndef DCPWM_REGS_VH
`define DCPWM_REGS_VH

// Byte register indices
`define DCPWM_IDX_DUTY0 10'h090
`define DCPWM_IDX_DUTY1 10'h091
`define DCPWM_IDX_DUTY2 10'h092
`define DCPWM_IDX_DUTY3 10'h093
`define DCPWM_IDX_PER0 10'h094
`define DCPWM_IDX_PER1 10'h095
`define DCPWM_IDX_CNT0 10'h096
`define DCPWM_IDX_CNT1 10'h097
`define DCPWM_IDX_MAIN 10'h098
`define DCPWM_IDX_SPEED 10'h099

// Word views of register pairs
`define DCPWM_IDX_WDUTYA 10'h0a0
`define DCPWM_IDX_WDUTYB 10'h0a1
`define DCPWM_IDX_WPER 10'h0a2
`define DCPWM_IDX_WCNT 10'h0a3

// Reset values
`define DCPWM_RST_BYTE 8'h00
`define DCPWM_RST_SPEED 8'hfe
`define DCPWM_RST_FAST 1'b0
`define DCPWM_SPEED_FILL 7'h7f

// Main control fields
`define DCPWM_B_RUN0 0
`define DCPWM_B_CKS0A 1
`define DCPWM_B_CKS0B 2
`define DCPWM_B_IRQS0 3
`define DCPWM_B_RUN1 4
`define DCPWM_B_CKS1A 5
`define DCPWM_B_CKS1B 6
`define DCPWM_B_IRQS1 7
// Speed mode control field
`define DCPWM_B_FAST 0

// Count clock selects
`define DCPWM_CKS_DIV1 2'b00
`define DCPWM_CKS_DIV2 2'b01
`define DCPWM_CKS_DIV4 2'b10
`define DCPWM_CKS_CASC 2'b11
`define DCPWM_CNT_MAX 8'hff

`endif

/* hw/dcpwm_unit.v */
// Dual counter PWM unit: two reloading 8-bit up-counters, four duty channels,
// 16-bit cascade and interleaved fast mode, registers on an APB slave.
// Assumes a 100 MHz pclk, an APB4 master and an external pin mux for outputs.
//
// What this block does
// - Four 8-bit channels, two per shared counter
// - Counters cascade into one 16-bit counter
// - Fast bit acts only in cascaded mode
// - Counters count up, reload on overflow
// - Counters read/write bytewise or as word
// - Counter write also loads its period register
// - Period registers bytewise or word, high upper
// - Duty registers bytewise or two words
// - Reset clears counters, periods, duties, control
// - Speed register upper bits read one, ignored
// - Period 0 for channels 0,2; 1 for 1,3
// - Main bits 1-2 clock, bit 3 irq0
// - Main bit 0 runs counter 0, with bit 4 if cascaded; bit 4 alone in fast mode
// - Bits 5-6 clock, 7 irq1, 4 run
// - Outputs held high when idle or halted
// - Period is count clock times 256 (65536 when cascaded) minus reload
// - Start and overflow set output high
// - Compare match raises irq, clears output
// - Both counter 1 selects high cascade counters
// - Fast mode interleaves, output high while at or below
`timescale 1ns/100ps
`default_nettype none
`include "dcpwm_regs.vh"

module dcpwm_unit (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Waveform outputs
    output reg wave_out_0,
    output reg wave_out_1,
    output reg wave_out_2,
    output reg wave_out_3,
    // Interrupt request pulses
    output reg wave_irq_0,
    output reg wave_irq_1,
    output reg wave_irq_2,
    output reg wave_irq_3
);

    // Register state
    reg [7:0] duty0_q; // Duty value 0
    reg [7:0] duty1_q; // Duty value 1
    reg [7:0] duty2_q; // Duty value 2
    reg [7:0] duty3_q; // Duty value 3
    reg [7:0] per0_q; // Low period reload
    reg [7:0] per1_q; // High period reload
    reg [7:0] lo_q; // Low counter
    reg [7:0] hi_q; // High counter
    reg [7:0] main_q; // Main control
    reg fast_q; // Fast interleave select
    reg [2:0] presc_q; // Free prescaler for count enables
    reg lo_run_q; // Last cycle's low run state
    reg hi_run_q; // Last cycle's high run state

    // Next counter values
    reg [7:0] lo_d;
    reg [7:0] hi_d;
    reg ovl; // Low counter overflow pulse
    reg ovh; // High (or 16-bit) overflow pulse

    // Decode results
    reg [31:0] rd_c;
    reg hit_c;
    reg wide_c;
    reg [9:0] wb_c;

    wire [9:0] idx = paddr[11:2];
    wire acc = psel & penable & ~pready;
    wire wr_fire = psel & penable & pready & pwrite;
    wire [9:0] we = wb_c & {10{wr_fire & hit_c}};
    // Upper byte of a word view takes lane 1
    wire [7:0] d_odd = wide_c ? pwdata[15:8] : pwdata[7:0];
    wire [7:0] d_even = pwdata[7:0];

    // Field views
    wire run0 = main_q[`DCPWM_B_RUN0];
    wire run1 = main_q[`DCPWM_B_RUN1];
    wire [1:0] cks0 = {main_q[`DCPWM_B_CKS0B], main_q[`DCPWM_B_CKS0A]};
    wire [1:0] cks1 = {main_q[`DCPWM_B_CKS1B], main_q[`DCPWM_B_CKS1A]};
    wire cascade = (cks1 == `DCPWM_CKS_CASC);
    wire fast = cascade & fast_q;

    // Run gating: in fast mode only the high run bit starts and stops
    wire lo_run = fast ? run1 : (cascade ? (run0 & run1) : run0);
    wire hi_run = cascade ? lo_run : run1;
    wire lo_rise = lo_run & ~lo_run_q;
    wire hi_rise = hi_run & ~hi_run_q;

    // Count enables from the prescaler
    function ckt;
        input [1:0] sel;
        input [2:0] p;
        begin
            if (sel == `DCPWM_CKS_DIV1) begin
                ckt = 1'b1;
            end else if (sel == `DCPWM_CKS_DIV2) begin
                ckt = p[0];
            end else if (sel == `DCPWM_CKS_DIV4) begin
                ckt = &p[1:0];
            end else begin
                ckt = &p[2:0];
            end
        end
    endfunction

    wire tick_lo = lo_run & ckt(cks0, presc_q);
    wire tick_hi = run1 & ~cascade & ckt(cks1, presc_q);

    // Compare views
    wire [15:0] cnt16 = {hi_q, lo_q};
    wire [15:0] duty_a = {duty1_q, duty0_q};
    wire [15:0] duty_b = {duty3_q, duty2_q};
    wire lo_max = (lo_q == `DCPWM_CNT_MAX);
    wire hi_max = (hi_q == `DCPWM_CNT_MAX);
    wire m0 = tick_lo & (lo_q == duty0_q);
    wire m2 = tick_lo & (lo_q == duty2_q);
    wire m1 = tick_hi & (hi_q == duty1_q);
    wire m3 = tick_hi & (hi_q == duty3_q);
    wire ma = tick_lo & (cnt16 == duty_a);
    wire mb = tick_lo & (cnt16 == duty_b);

    // Address decode; word views steer lane 1 into the upper byte
    always @* begin
        rd_c = 32'h0000_0000;
        hit_c = 1'b1;
        wide_c = 1'b0;
        wb_c = 10'h000;
        if (idx == `DCPWM_IDX_DUTY0) begin
            rd_c = {24'h00_0000, duty0_q};
            wb_c[0] = pstrb[0];
        end else if (idx == `DCPWM_IDX_DUTY1) begin
            rd_c = {24'h00_0000, duty1_q};
            wb_c[1] = pstrb[0];
        end else if (idx == `DCPWM_IDX_DUTY2) begin
            rd_c = {24'h00_0000, duty2_q};
            wb_c[2] = pstrb[0];
        end else if (idx == `DCPWM_IDX_DUTY3) begin
            rd_c = {24'h00_0000, duty3_q};
            wb_c[3] = pstrb[0];
        end else if (idx == `DCPWM_IDX_PER0) begin
            rd_c = {24'h00_0000, per0_q};
            wb_c[4] = pstrb[0];
        end else if (idx == `DCPWM_IDX_PER1) begin
            rd_c = {24'h00_0000, per1_q};
            wb_c[5] = pstrb[0];
        end else if (idx == `DCPWM_IDX_CNT0) begin
            rd_c = {24'h00_0000, lo_q};
            wb_c[6] = pstrb[0];
        end else if (idx == `DCPWM_IDX_CNT1) begin
            rd_c = {24'h00_0000, hi_q};
            wb_c[7] = pstrb[0];
        end else if (idx == `DCPWM_IDX_MAIN) begin
            rd_c = {24'h00_0000, main_q};
            wb_c[8] = pstrb[0];
        end else if (idx == `DCPWM_IDX_SPEED) begin
            rd_c = {24'h00_0000, `DCPWM_SPEED_FILL, fast_q};
            wb_c[9] = pstrb[0];
        end else if (idx == `DCPWM_IDX_WDUTYA) begin
            rd_c = {16'h0000, duty1_q, duty0_q};
            wide_c = 1'b1;
            wb_c[0] = pstrb[0];
            wb_c[1] = pstrb[1];
        end else if (idx == `DCPWM_IDX_WDUTYB) begin
            rd_c = {16'h0000, duty3_q, duty2_q};
            wide_c = 1'b1;
            wb_c[2] = pstrb[0];
            wb_c[3] = pstrb[1];
        end else if (idx == `DCPWM_IDX_WPER) begin
            rd_c = {16'h0000, per1_q, per0_q};
            wide_c = 1'b1;
            wb_c[4] = pstrb[0];
            wb_c[5] = pstrb[1];
        end else if (idx == `DCPWM_IDX_WCNT) begin
            rd_c = {16'h0000, hi_q, lo_q};
            wide_c = 1'b1;
            wb_c[6] = pstrb[0];
            wb_c[7] = pstrb[1];
        end else begin
            hit_c = 1'b0; // Unmapped: error answer, no effect
        end
    end

    // APB answer: one wait state so every bus output comes from a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= acc;
            if (acc) begin
                pslverr <= ~hit_c;
                prdata <= (hit_c & ~pwrite) ? rd_c : 32'h0000_0000;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Counter next state; software writes win over counting
    always @* begin
        lo_d = lo_q;
        hi_d = hi_q;
        ovl = 1'b0;
        ovh = 1'b0;
        if (fast) begin
            // Upper byte steps fastest and carries into the lower byte
            if (tick_lo) begin
                hi_d = hi_q + 8'h01;
                if (hi_max) begin
                    lo_d = lo_q + 8'h01;
                    if (lo_max) begin
                        ovh = 1'b1;
                        lo_d = per0_q;
                        hi_d = per1_q;
                    end
                end
            end
        end else begin
            if (tick_lo) begin
                if (lo_max) begin
                    ovl = 1'b1;
                    // Cascaded: low wraps unless the whole word overflows
                    lo_d = (cascade & ~hi_max) ? 8'h00 : per0_q;
                end else begin
                    lo_d = lo_q + 8'h01;
                end
            end
            if ((cascade & ovl) | tick_hi) begin
                if (hi_max) begin
                    ovh = 1'b1;
                    hi_d = per1_q;
                end else begin
                    hi_d = hi_q + 8'h01;
                end
            end
        end
        if (we[6]) begin
            lo_d = d_even;
        end
        if (we[7]) begin
            hi_d = d_odd;
        end
    end

    // Register file and counters
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty0_q <= `DCPWM_RST_BYTE;
            duty1_q <= `DCPWM_RST_BYTE;
            duty2_q <= `DCPWM_RST_BYTE;
            duty3_q <= `DCPWM_RST_BYTE;
            per0_q <= `DCPWM_RST_BYTE;
            per1_q <= `DCPWM_RST_BYTE;
            lo_q <= `DCPWM_RST_BYTE;
            hi_q <= `DCPWM_RST_BYTE;
            main_q <= `DCPWM_RST_BYTE;
            fast_q <= `DCPWM_RST_FAST;
            presc_q <= 3'h0;
            lo_run_q <= 1'b0;
            hi_run_q <= 1'b0;
        end else begin
            presc_q <= presc_q + 3'h1;
            lo_run_q <= lo_run;
            hi_run_q <= hi_run;
            lo_q <= lo_d;
            hi_q <= hi_d;
            if (we[0]) begin
                duty0_q <= d_even;
            end
            if (we[1]) begin
                duty1_q <= d_odd;
            end
            if (we[2]) begin
                duty2_q <= d_even;
            end
            if (we[3]) begin
                duty3_q <= d_odd;
            end
            // A counter write lands in its period register too
            if (we[4] | we[6]) begin
                per0_q <= d_even;
            end
            if (we[5] | we[7]) begin
                per1_q <= d_odd;
            end
            if (we[8]) begin
                main_q <= d_even;
            end
            if (we[9]) begin
                fast_q <= d_even[`DCPWM_B_FAST];
            end
        end
    end

    // Low group outputs; unused as waveforms while cascaded
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_out_0 <= 1'b1;
            wave_out_2 <= 1'b1;
        end else if (!lo_run | cascade | lo_rise) begin
            wave_out_0 <= 1'b1;
            wave_out_2 <= 1'b1;
        end else if (tick_lo & lo_max) begin
            wave_out_0 <= 1'b1;
            wave_out_2 <= 1'b1;
        end else begin
            // Match drops the level; a duty of 0xff never matches before overflow
            if (m0) begin
                wave_out_0 <= 1'b0;
            end
            if (m2) begin
                wave_out_2 <= 1'b0;
            end
        end
    end

    // High group outputs: 8-bit, cascaded 16-bit or fast interleaved
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_out_1 <= 1'b1;
            wave_out_3 <= 1'b1;
        end else if (!hi_run | hi_rise) begin
            wave_out_1 <= 1'b1;
            wave_out_3 <= 1'b1;
        end else if (fast) begin
            // Level compare spreads the high time over many short pulses
            wave_out_1 <= (cnt16 <= duty_a);
            wave_out_3 <= (cnt16 <= duty_b);
        end else if (cascade) begin
            if (tick_lo & lo_max & hi_max) begin
                wave_out_1 <= 1'b1;
                wave_out_3 <= 1'b1;
            end else begin
                if (ma) begin
                    wave_out_1 <= 1'b0;
                end
                if (mb) begin
                    wave_out_3 <= 1'b0;
                end
            end
        end else if (tick_hi & hi_max) begin
            wave_out_1 <= 1'b1;
            wave_out_3 <= 1'b1;
        end else begin
            if (m1) begin
                wave_out_1 <= 1'b0;
            end
            if (m3) begin
                wave_out_3 <= 1'b0;
            end
        end
    end

    // Interrupt request pulses; low-byte matches still raise 0 and 2 when cascaded, but not in fast mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_irq_0 <= 1'b0;
            wave_irq_1 <= 1'b0;
            wave_irq_2 <= 1'b0;
            wave_irq_3 <= 1'b0;
        end else begin
            wave_irq_0 <= fast ? 1'b0 : (main_q[`DCPWM_B_IRQS0] ? ovl : m0);
            wave_irq_2 <= fast ? 1'b0 : m2;
            if (cascade) begin
                wave_irq_1 <= main_q[`DCPWM_B_IRQS1] ? ovh : ma;
                wave_irq_3 <= mb;
            end else begin
                wave_irq_1 <= main_q[`DCPWM_B_IRQS1] ? ovh : m1;
                wave_irq_3 <= m3;
            end
        end
    end

endmodule
`default_nettype wire

/* hw/dcpwm_unit_spare.v */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* bench/dcpwm_unit_assertions.sv */
// Checker for the dual counter PWM unit, bound to its top module.
// Assumes one APB wait state and registered outputs, as handed over.
`timescale 1ns/100ps
`default_nettype none
`include "dcpwm_regs.vh"
module dcpwm_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and requests
    input wire logic wave_out_0,
    input wire logic wave_out_1,
    input wire logic wave_out_2,
    input wire logic wave_out_3,
    input wire logic wave_irq_0,
    input wire logic wave_irq_1,
    input wire logic wave_irq_2,
    input wire logic wave_irq_3
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access phase still waiting for the slave
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    // Completed control write that stops both counters
    sequence s_halt;
        psel && penable && pready && pwrite && pstrb[0] && paddr[11:2] == `DCPWM_IDX_MAIN
            && !pwdata[0] && !pwdata[4];
    endsequence
    property p_ready_next;
        s_wait |=> pready;
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("ready late");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("stray error");
    property p_err_unmapped;
        psel && pready && paddr[11:2] > `DCPWM_IDX_WCNT |-> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped accepted");
    property p_speed_read;
        psel && pready && !pwrite && paddr[11:2] == `DCPWM_IDX_SPEED |-> prdata[31:1] == 31'h7f;
    endproperty
    a_speed_read: assert property (p_speed_read) else $error("speed fill bits");
    property p_reset_high;
        $rose(presetn) |-> wave_out_0 && wave_out_1 && wave_out_2 && wave_out_3 && !wave_irq_1;
    endproperty
    a_reset_high: assert property (p_reset_high) else $error("reset levels");
    property p_halt;
        s_halt |=> ##[0:2] (wave_out_0 && wave_out_1 && wave_out_2 && wave_out_3);
    endproperty
    a_halt: assert property (p_halt) else $error("halt not high");
    property p_fall_irq;
        $fell(wave_out_2) |-> ##[0:2] wave_irq_2;
    endproperty
    a_fall_irq: assert property (p_fall_irq) else $error("match without request");
    property p_irq_once;
        wave_irq_2 |=> !wave_irq_2;
    endproperty
    a_irq_once: assert property (p_irq_once) else $error("request too long");
endmodule
bind dcpwm_unit dcpwm_chk u_dcpwm_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .wave_out_0, .wave_out_1, .wave_out_2,
    .wave_out_3, .wave_irq_0, .wave_irq_1, .wave_irq_2, .wave_irq_3);
`default_nettype wire

/* bench/dcpwm_load.sv */
// Load model on one PWM pin: times period and high phase.
// Assumes the pin is sampled on pclk, the same clock as the unit.
`timescale 1ns/100ps
`default_nettype none
module dcpwm_load (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched pin
    input wire logic wave,
    // Last period and high time, in pclk cycles
    output var logic [15:0] period_q,
    output var logic [15:0] high_q
);
    logic wave_q; // Pin one cycle ago
    logic [15:0] since_q; // Cycles since last rise
    // Rise to rise gives the period, rise to fall the high time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_q <= 1'b1;
            since_q <= '0;
            period_q <= '0;
            high_q <= '0;
        end else begin
            wave_q <= wave;
            since_q <= since_q + 16'h0001;
            // Rise restarts timing; a halt-to-start rise gives junk, so read late
            if (wave && !wave_q) begin
                period_q <= since_q + 16'h0001;
                since_q <= '0;
            end
            // Fall closes the high phase
            if (!wave && wave_q) begin
                high_q <= since_q + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* bench/dcpwm_unit_tb.sv */
// Testbench for the dual counter PWM unit: registers over APB, pin timing.
// Assumes the bound checker and two load models, one on a selectable pin and one on that pin's request line.
`timescale 1ns/100ps
`default_nettype none
`include "dcpwm_regs.vh"
module dcpwm_unit_tb;
    logic pclk = 1'b0; // System clock
    logic presetn = 1'b0; // Reset, active low
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] wave; // Pins 3 to 0
    logic [3:0] irq; // Requests 3 to 0
    logic [1:0] mon_sel = '0; // Pin the load watches
    logic [15:0] mon_per;
    logic [15:0] mon_hi;
    logic [15:0] irq_per; // Spacing of request pulses on the watched channel
    logic [15:0] irq_hi; // Width of the last request pulse
    logic [31:0] rd; // Last read data
    logic err; // Last error response
    int bad_count = 0;
    int num_checks = 0;
    // Free-running 100 MHz clock
    always #5 pclk = ~pclk;
    dcpwm_unit u_dcpwm_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wave_out_0(wave[0]), .wave_out_1(wave[1]),
        .wave_out_2(wave[2]), .wave_out_3(wave[3]), .wave_irq_0(irq[0]), .wave_irq_1(irq[1]),
        .wave_irq_2(irq[2]), .wave_irq_3(irq[3]));
    dcpwm_load u_dcpwm_load (.pclk(pclk), .presetn(presetn), .wave(wave[mon_sel]),
        .period_q(mon_per), .high_q(mon_hi));
    // Same timer on the watched channel's request line
    dcpwm_load u_dcpwm_load_irq (.pclk(pclk), .presetn(presetn), .wave(irq[mon_sel]),
        .period_q(irq_per), .high_q(irq_hi));
    // Prints counts and verdict, then stops
    task automatic final_report();
        $display("Checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Compares one value; four-state so unknowns fail
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Ends once pready is seen; the watchdog catches a hang
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [15:0] v);
        apb(1'b1, idx, v);
    endtask
    task automatic chk(input logic [9:0] idx, input logic [15:0] exp);
        apb(1'b0, idx, 16'h0000);
        check(rd, {16'h0000, exp});
    endtask
    // Runs one channel, times its pin, then halts and checks the idle level
    task automatic run_case(input logic [7:0] main, input logic [9:0] cidx,
        input logic [15:0] cval, input logic [9:0] didx, input logic [15:0] dval,
        input logic [1:0] ch, input logic [15:0] per, input logic [15:0] hi);
        wr(cidx, cval);
        wr(didx, dval);
        mon_sel <= ch;
        wr(`DCPWM_IDX_MAIN, {8'h00, main});
        // Several periods so the first one, timed from a rise before the start, is overwritten
        repeat (4 * per + 20) @(posedge pclk);
        check(mon_per, per);
        check(mon_hi, hi);
        // One single-cycle request per period on the same channel
        check(irq_per, per);
        check(irq_hi, 16'h0001);
        if (main[6:5] == 2'b11) check(wave[0], 1'b1);
        wr(`DCPWM_IDX_MAIN, 16'h0000);
        repeat (3) @(posedge pclk);
        check(wave, 4'hf);
    endtask
    // Levels and register contents right after a reset
    task automatic chk_reset();
        check(wave, 4'hf);
        check(irq, 4'h0);
        for (int i = 'h90; i < 'h99; i++) chk(i[9:0], 16'h0000);
        chk(`DCPWM_IDX_SPEED, 16'h00fe);
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        final_report();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_reset();
        wr(`DCPWM_IDX_SPEED, 16'h0000);
        chk(`DCPWM_IDX_SPEED, 16'h00fe);
        wr(`DCPWM_IDX_DUTY0, 16'h005a);
        wr(`DCPWM_IDX_DUTY1, 16'h00a5);
        chk(`DCPWM_IDX_WDUTYA, 16'ha55a);
        wr(`DCPWM_IDX_WDUTYB, 16'h1234);
        chk(`DCPWM_IDX_DUTY3, 16'h0012);
        chk(`DCPWM_IDX_DUTY2, 16'h0034);
        wr(`DCPWM_IDX_WPER, 16'hbeef);
        chk(`DCPWM_IDX_PER1, 16'h00be);
        chk(`DCPWM_IDX_PER0, 16'h00ef);
        wr(`DCPWM_IDX_CNT1, 16'h0077);
        chk(`DCPWM_IDX_WPER, 16'h77ef);
        chk(`DCPWM_IDX_WCNT, 16'h7700);
        wr(`DCPWM_IDX_WCNT, 16'h1122);
        chk(`DCPWM_IDX_CNT0, 16'h0022);
        chk(`DCPWM_IDX_WPER, 16'h1122);
        wr(`DCPWM_IDX_MAIN, 16'h00ae);
        chk(`DCPWM_IDX_MAIN, 16'h00ae);
        apb(1'b0, 10'h3ff, 16'h0000);
        check(err, 1'b1);
        wr(`DCPWM_IDX_SPEED, 16'h00ff);
        chk(`DCPWM_IDX_SPEED, 16'h00ff);
        // Fast bit set, but 8-bit mode must ignore it; request 0 from overflow
        run_case(8'h09, `DCPWM_IDX_CNT0, 16'h00f0, `DCPWM_IDX_DUTY0, 16'h00f8, 2'd0, 16, 9);
        run_case(8'h03, `DCPWM_IDX_CNT0, 16'h00f0, `DCPWM_IDX_DUTY2, 16'h00f4, 2'd2, 32, 10);
        run_case(8'h50, `DCPWM_IDX_CNT1, 16'h00f0, `DCPWM_IDX_DUTY3, 16'h00fc, 2'd3, 64, 52);
        wr(`DCPWM_IDX_SPEED, 16'h0000);
        // Cascaded, request 1 from the 16-bit overflow
        run_case(8'hf1, `DCPWM_IDX_WCNT, 16'hfff0, `DCPWM_IDX_WDUTYA, 16'hfff8, 2'd1, 16, 9);
        // Fast interleave: upper byte steps, level high while count <= duty
        wr(`DCPWM_IDX_SPEED, 16'h0001);
        run_case(8'h71, `DCPWM_IDX_WCNT, 16'hf0ff, `DCPWM_IDX_WDUTYA, 16'hf7ff, 2'd1, 16, 8);
        // Reset again after the last halt, with every register written
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_reset();
        final_report();
    end
endmodule
`default_nettype wire
